// ===== verilog/adc_ctrl_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 converter control unit. Assumes inclusion by bare name from the package.
*/
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

// Byte addresses of the 32-bit words on the register bus
`define OFS_RESULT_LOW 5'h00
`define OFS_RESULT_HIGH 5'h04
`define OFS_CONTROL 5'h08
`define OFS_CLOCK_SOURCE 5'h0C
`define OFS_IRQ_STATUS 5'h10
`define OFS_IRQ_MASK 5'h14
`define OFS_SAMPLE_IN 5'h18

// Control register fields
`define CTL_CHAN_LSB 0
`define CTL_DONE_BIT 6
`define CTL_START_BIT 7
`define CTL_PIN_LSB 3
// Clock source register fields
`define CSR_DIV_LSB 0
`define CSR_POWER_OFF_BIT 7

// Reset values
`define CONTROL_RESET 8'h40
`define CLOCK_SOURCE_RESET 8'h80

// Conversion length in conversion clock periods
`define CONV_PERIODS 16
// Half periods of the conversion clock in system clocks, per divide code
`define HALF_DIV2 5'h01
`define HALF_DIV8 5'h04
`define HALF_DIV32 5'h10

`endif

// ===== verilog/adc_ctrl_pkg.sv
/*
 Types of the converter control unit. Assumes the map header is on the
 include path.
*/
`include "adc_ctrl_map.svh"

package adc_ctrl_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_CONVERT
    } conv_state_t;

    // Converter control register contents
    typedef struct packed {
        logic start;
        logic done_n;
        logic [2:0] pin_config;
        logic [2:0] channel;
    } control_reg_t;

    // Signals to the analog front end
    typedef struct packed {
        logic power_on;
        logic core_reset;
        logic sample_clk;
        logic [2:0] channel;
        logic [5:0] analog_pin_en;
    } front_end_t;
endpackage : adc_ctrl_pkg

// ===== verilog/sar_adc_control_unit.sv
/*
 Control logic of a six-channel 12-bit converter: register file on an
 Avalon-MM slave, start sequencing, conversion clock divider, result latch
 and interrupt. Assumes a converter core that presents a 12-bit value on
 core_result, valid at the end of the sixteenth conversion clock period.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [R1] - six analog channels, twelve-bit result
// [R2] - result split high byte, low byte upper nibble
// [R3] - channel field routes one input to converter
// [R4] - pin field enables analog pins; 110/111 all
// [R5] - pin field zero: plain I/O, converter off
// [R6] - start low-high-low begins one conversion
// [R7] - start held high resets core, done high
// [R8] - done flag drops low at conversion end
// [R9] - conversion end sets interrupt request flag
// [R10] - software may poll done flag instead
// [R11] - power-off bit shuts converter down
// [R12] - converter on: pins nonzero, power-off clear
// [R13] - divide code 000/001/010 gives 2/8/32
// [R14] - software keeps conversion period at least 0.5us
// [R15] - conversion lasts sixteen conversion clock periods
// [R16] - software pulses start after channel change
// [R17] - result bytes update with done flag
// [R18] - start sampled, falling edge after rising starts
module sar_adc_control_unit
    import adc_ctrl_pkg::*;
#(
    parameter int CHANNELS = 6,
    parameter int RES_BITS = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Converter core
    input wire logic [RES_BITS-1:0] core_result,
    output front_end_t front_end,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] result_high_ff;
    logic [7:0] result_low_ff;
    control_reg_t control_ff;
    logic [7:0] clock_source_ff;
    logic irq_status_ff;
    logic irq_mask_ff;
    conv_state_t state_ff;
    logic [4:0] div_cnt_ff;
    logic sample_clk_ff;
    logic [4:0] period_cnt_ff;
    logic done_event;
    logic tick;
    logic [4:0] half_div;
    logic power_on;
    logic [5:0] pin_en;
    logic wr_acc;
    logic rd_acc;
    logic [31:0] nxt_readdata;
    logic start_ff;
    logic start_prev_ff;
    logic accept_ff;

    // Single-cycle accept: waitrequest drops the cycle after a request
    assign wr_acc = avs_write & accept_ff;
    assign rd_acc = avs_read & accept_ff;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    // One wait state keeps readdata registered with the request held
    always_ff @(posedge clk) begin
        if (!nrst) begin
            accept_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            accept_ff <= (avs_read | avs_write) & ~accept_ff;
            avs_waitrequest <= ~((avs_read | avs_write) & ~accept_ff);
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        nxt_readdata = 32'h0000_0000;
        unique case (avs_address)
            `OFS_RESULT_LOW: nxt_readdata[7:0] = result_low_ff; // [R2]
            `OFS_RESULT_HIGH: nxt_readdata[7:0] = result_high_ff; // [R2]
            `OFS_CONTROL: nxt_readdata[7:0] = control_ff;
            `OFS_CLOCK_SOURCE: nxt_readdata[7:0] = clock_source_ff;
            `OFS_IRQ_STATUS: nxt_readdata[0] = irq_status_ff;
            `OFS_IRQ_MASK: nxt_readdata[0] = irq_mask_ff;
            `OFS_SAMPLE_IN: nxt_readdata[RES_BITS-1:0] = core_result;
            default: nxt_readdata = 32'h0000_0000;
        endcase
    end

    // Registered read data, valid at the edge waitrequest is low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~accept_ff) begin
            avs_readdata <= nxt_readdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and clock source registers

    // Software fields; done flag owned by the sequencer below
    always_ff @(posedge clk) begin
        if (!nrst) begin
            control_ff.start <= 1'b0;
            control_ff.pin_config <= 3'h0;
            control_ff.channel <= 3'h0;
            clock_source_ff <= `CLOCK_SOURCE_RESET;
        end else if (wr_acc && avs_byteenable[0]) begin
            if (avs_address == 5'(`OFS_CONTROL)) begin
                control_ff.start <= avs_writedata[`CTL_START_BIT];
                control_ff.pin_config <= avs_writedata[`CTL_PIN_LSB +: 3]; // [R4]
                control_ff.channel <= avs_writedata[`CTL_CHAN_LSB +: 3]; // [R3]
            end
            if (avs_address == 5'(`OFS_CLOCK_SOURCE)) begin
                clock_source_ff <= avs_writedata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power and pin sharing

    // Either off condition wins; both are independent
    assign power_on = (control_ff.pin_config != 3'h0) &
                      ~clock_source_ff[`CSR_POWER_OFF_BIT]; // [R5] [R11] [R12]

    // Codes 1..5 enable that many pins; 6 and 7 enable all six
    always_comb begin
        unique case (control_ff.pin_config)
            3'h0: pin_en = 6'h00; // [R5]
            3'h1: pin_en = 6'h01;
            3'h2: pin_en = 6'h03;
            3'h3: pin_en = 6'h07;
            3'h4: pin_en = 6'h0F;
            3'h5: pin_en = 6'h1F;
            default: pin_en = 6'h3F; // [R4]
        endcase
    end

    // Front-end outputs straight from flip-flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            front_end.power_on <= 1'b0;
            front_end.core_reset <= 1'b1;
            front_end.channel <= 3'h0;
            front_end.analog_pin_en <= 6'h00;
        end else begin
            front_end.power_on <= power_on; // [R12]
            front_end.core_reset <= control_ff.start | ~power_on; // [R7]
            front_end.channel <= control_ff.channel; // [R1] [R3]
            front_end.analog_pin_en <= pin_en; // [R4] [R5]
        end
    end
    assign front_end.sample_clk = sample_clk_ff;

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock divider

    // Code 011 and above undefined; treated as divide by 32
    always_comb begin
        unique case (clock_source_ff[`CSR_DIV_LSB +: 3])
            3'h0: half_div = `HALF_DIV2; // [R13]
            3'h1: half_div = `HALF_DIV8; // [R13]
            default: half_div = `HALF_DIV32; // [R13]
        endcase
    end

    // Divider runs only during a conversion so period one is whole;
    // start or power loss stops it at once, in the same edge as the core reset rises
    always_ff @(posedge clk) begin
        if (!nrst || state_ff != ST_CONVERT || control_ff.start || !power_on) begin // [R7]
            div_cnt_ff <= 5'h00;
            sample_clk_ff <= 1'b0;
        end else if (div_cnt_ff == half_div - 5'h01) begin
            div_cnt_ff <= 5'h00;
            sample_clk_ff <= ~sample_clk_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 5'h01;
        end
    end

    // One tick per full conversion clock period (falling edge)
    assign tick = (state_ff == ST_CONVERT) && sample_clk_ff &&
                  (div_cnt_ff == half_div - 5'h01);

    ////////////////////////////////////////////////////////////////////////
    // Start sequencing

    // Start history for edge detection in the system clock domain
    always_ff @(posedge clk) begin
        if (!nrst) begin
            start_ff <= 1'b0;
            start_prev_ff <= 1'b0;
        end else begin
            start_ff <= control_ff.start;
            start_prev_ff <= start_ff;
        end
    end

    // Sequencer: armed on rise, converts on fall, sixteen periods
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            period_cnt_ff <= 5'h00;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start_ff && !start_prev_ff) begin
                        state_ff <= ST_ARMED; // [R18]
                    end
                end
                ST_ARMED: begin
                    if (!start_ff && start_prev_ff) begin
                        state_ff <= power_on ? ST_CONVERT : ST_IDLE; // [R6] [R18]
                        period_cnt_ff <= 5'h00;
                    end
                end
                ST_CONVERT: begin
                    if (start_ff || !power_on) begin
                        state_ff <= start_ff ? ST_ARMED : ST_IDLE; // [R7]
                    end else if (tick) begin
                        if (period_cnt_ff == 5'(`CONV_PERIODS - 1)) begin
                            state_ff <= ST_IDLE; // [R15]
                        end
                        period_cnt_ff <= period_cnt_ff + 5'h01;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    assign done_event = (state_ff == ST_CONVERT) && !start_ff && power_on && tick &&
                        (period_cnt_ff == 5'(`CONV_PERIODS - 1));

    ////////////////////////////////////////////////////////////////////////
    // Done flag and result

    // Done high while start high; low at conversion end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            control_ff.done_n <= 1'(`CONTROL_RESET >> `CTL_DONE_BIT);
        end else if (done_event) begin
            control_ff.done_n <= 1'b0; // [R8]
        end else if (control_ff.start) begin
            control_ff.done_n <= 1'b1; // [R7] [R16]
        end
    end

    // Both bytes latched in the same edge as the done flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            result_high_ff <= 8'h00;
            result_low_ff <= 8'h00;
        end else if (done_event) begin
            result_high_ff <= core_result[11:4]; // [R2] [R17]
            result_low_ff <= {core_result[3:0], 4'h0}; // [R2] [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt

    // Sticky flag, write one to clear; a new event beats the clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_status_ff <= 1'b0;
            irq_mask_ff <= 1'b0;
        end else begin
            if (done_event) begin
                irq_status_ff <= 1'b1; // [R9]
            end else if (wr_acc && avs_byteenable[0] &&
                         avs_address == `OFS_IRQ_STATUS && avs_writedata[0]) begin
                irq_status_ff <= 1'b0;
            end
            if (wr_acc && avs_byteenable[0] && avs_address == `OFS_IRQ_MASK) begin
                irq_mask_ff <= avs_writedata[0];
            end
        end
    end

    // Level output, registered; lags the flag by one cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_status_ff & irq_mask_ff; // [R9]
        end
    end

endmodule : sar_adc_control_unit

`default_nettype wire

// ===== dv/adc_core_model.sv
/*
 Behavioural converter core: a fixed code per routed channel.
 Assumes the front end struct of the design package.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_core_model
    import adc_ctrl_pkg::*;
(
    // Clock
    input wire logic clk,
    // Front end from the control unit
    input wire front_end_t front_end,
    output logic [11:0] core_result
);
    // Powered: channel code; off: pattern flips so stale values never pass
    always @(posedge clk) begin
        if (front_end.power_on) begin
            core_result <= {3'h5, front_end.channel, 6'h2D};
        end else begin
            core_result <= (core_result === 12'hA5A) ? 12'h5A5 : 12'hA5A;
        end
    end
endmodule : adc_core_model
`default_nettype wire

// ===== dv/sar_adc_control_unit_assertions.sv
/*
 Port checker of the converter control unit.
 Assumes the design package is compiled first; bound below.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_checker
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Front end
    input wire front_end_t front_end
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // A fresh request after idle
    sequence req_s;
        $rose(avs_read || avs_write);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // Bus timing, one wait state
    wait_one_a: assert property (req_s |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:12] == 20'h0)
        else $error("read data upper bits set");
    read_hold_a: assert property ((!avs_read) [*2] |-> $stable(avs_readdata))
        else $error("read data moved without a read");
    ////////////////////////////////////////////////////////////////////////
    // Pins and power, two cycles allowed for flop skew
    pin_pattern_a: assert property ($onehot0(front_end.analog_pin_en + 6'h01))
        else $error("analog pin enables not a low run");
    pin_power_a: assert property ((front_end.analog_pin_en == 6'h00) [*2] |-> !front_end.power_on)
        else $error("converter powered with no analog pins");
    off_reset_a: assert property ((!front_end.power_on) [*2] |-> front_end.core_reset)
        else $error("core out of reset while powered off");
    clk_idle_a: assert property (front_end.core_reset [*2] |-> !front_end.sample_clk)
        else $error("conversion clock runs during core reset");
endmodule : adc_ctrl_checker
bind sar_adc_control_unit adc_ctrl_checker checker_i (
    .clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .front_end(front_end));
`default_nettype wire

// ===== dv/tb.sv
/*
 Testbench of the converter control unit.
 Assumes design, package, core model and checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    import adc_ctrl_pkg::*;
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [11:0] core_result;
    front_end_t front_end;
    int n_errors, n_tests, k;
    sar_adc_control_unit dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_result(core_result),
        .front_end(front_end), .irq(irq));
    adc_core_model core_i (.clk(clk), .front_end(front_end), .core_result(core_result));
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One bus cycle; held until waitrequest is seen low, then two idle
    // cycles so registered outputs fed by the write have settled
    task acc(input logic [4:0] a, input logic w, input logic [31:0] d);
        int i;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            report_and_stop();
        end
        @(posedge clk);
        @(posedge clk);
    endtask : acc
    // Start pulse, then time and check one conversion
    task conv(input logic [2:0] ch, input logic [2:0] dv, input int per);
        int n;
        acc(`OFS_CLOCK_SOURCE, 1, {29'h0, dv});
        acc(`OFS_CONTROL, 1, {24'h0, 5'h16, ch});
        acc(`OFS_CONTROL, 0, 32'h0);
        chk(q[7:6], 2'h3);
        chk(front_end.core_reset, 1'b1);
        acc(`OFS_CONTROL, 1, {24'h0, 5'h06, ch});
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk(n >= per - 2 && n <= per + 10, 1'b1);
        if (n >= 600) report_and_stop();
        chk(front_end.channel, ch);
        acc(`OFS_RESULT_HIGH, 0, 32'h0);
        chk(q, {24'h0, 3'h5, ch, 2'h2});
        acc(`OFS_RESULT_LOW, 0, 32'h0);
        chk(q[7:4], 4'hD);
        acc(`OFS_CONTROL, 0, 32'h0);
        chk(q[6], 1'b0);
        acc(`OFS_IRQ_STATUS, 0, 32'h0);
        chk(q[0], 1'b1);
        acc(`OFS_IRQ_STATUS, 1, 32'h1);
        chk(irq, 1'b0);
        $display("conversion test channel %0d done", ch);
    endtask : conv
    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Main sequence
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        n_errors = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        acc(`OFS_CONTROL, 0, 32'h0);
        chk(q, 32'h40);
        acc(`OFS_CLOCK_SOURCE, 0, 32'h0);
        chk(q, 32'h80);
        acc(5'h1C, 0, 32'h0);
        chk(q, 32'h0);
        $display("reset test done");
        // Every pin code with power allowed, then the power-off bit
        acc(`OFS_CLOCK_SOURCE, 1, 32'h0);
        for (k = 0; k < 8; k++) begin
            acc(`OFS_CONTROL, 1, k << 3);
            chk(front_end.analog_pin_en, k == 0 ? 6'h00 : k > 5 ? 6'h3F : (6'h01 << k) - 6'h01);
            chk(front_end.power_on, k != 0);
        end
        acc(`OFS_CLOCK_SOURCE, 1, 32'h80);
        chk(front_end.power_on, 1'b0);
        $display("power test done");
        acc(`OFS_IRQ_MASK, 1, 32'h1);
        conv(3'h0, 3'h0, 32);
        conv(3'h3, 3'h1, 128);
        conv(3'h5, 3'h2, 512);
        acc(`OFS_RESULT_HIGH, 1, 32'hFF);
        acc(`OFS_RESULT_HIGH, 0, 32'h0);
        chk(q, 32'hB6);
        // Masked: software polls the done flag instead
        acc(`OFS_IRQ_MASK, 1, 32'h0);
        acc(`OFS_CONTROL, 1, 32'hB0);
        acc(`OFS_CONTROL, 1, 32'h30);
        k = 0;
        do begin
            acc(`OFS_CONTROL, 0, 32'h0);
            k++;
        end while (q[6] !== 1'b0 && k < 200);
        chk(q[6], 1'b0);
        chk(irq, 1'b0);
        acc(`OFS_IRQ_MASK, 1, 32'h1);
        chk(irq, 1'b1);
        acc(`OFS_IRQ_STATUS, 1, 32'h1);
        chk(irq, 1'b0);
        $display("interrupt test done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
